// File: verilog/fcg_pkg.sv
// constants and microcode table for the floppy clock generator and data separator
package fcg_pkg;
    // oscillator and master clock, in kHz
    localparam int unsigned MCLK_KHZ   = 50000;
    localparam int unsigned OSC_KHZ    = 8000;
    // target rates, in kHz
    localparam int unsigned CTRL_KHZ   = 4000;
    localparam int unsigned WR_SD_KHZ  = 4000;
    localparam int unsigned WR_DD_KHZ  = 8000;
    localparam int unsigned REC_SD_KHZ = 250;
    localparam int unsigned REC_DD_KHZ = 500;
    // divide ratios from the oscillator, all powers of two
    localparam int unsigned CTRL_DIV   = OSC_KHZ / CTRL_KHZ;
    localparam int unsigned WR_SD_DIV  = OSC_KHZ / WR_SD_KHZ;
    localparam int unsigned WR_DD_DIV  = OSC_KHZ / WR_DD_KHZ;
    localparam int unsigned REC_SD_DIV = OSC_KHZ / REC_SD_KHZ;
    localparam int unsigned REC_DD_DIV = OSC_KHZ / REC_DD_KHZ;
    // widths
    localparam int unsigned DIV_W      = 5;
    localparam int unsigned ACC_W      = 17;
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NIB_W      = 4;
    // address fields
    localparam int unsigned PAGE_BIT   = 4;
    localparam int unsigned WIN_BIT    = 3;
    // reset state: free-run page, count zero
    localparam logic [4:0]  ADDR_RST   = 5'h10;
    localparam logic [3:0]  NIB_TOP    = 4'hF;
    localparam logic [3:0]  NIB_ZERO   = 4'h0;

    // sequencer table, 32 words of 8 bits
    function automatic logic [7:0] seq_rom(input logic [4:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            5'h00: d = 8'h01;
            5'h01: d = 8'h01;
            5'h02: d = 8'h02;
            5'h03: d = 8'h03;
            5'h04: d = 8'h03;
            5'h05: d = 8'h04;
            5'h06: d = 8'h05;
            5'h07: d = 8'h06;
            5'h08: d = 8'h0B;
            5'h09: d = 8'h0C;
            5'h0A: d = 8'h0D;
            5'h0B: d = 8'h0E;
            5'h0C: d = 8'h0E;
            5'h0D: d = 8'h0F;
            5'h0E: d = 8'h00;
            5'h0F: d = 8'h01;
            5'h1F: d = 8'h00;
            default: d = {4'h0, a[3:0] + 4'h1};
        endcase
        return d;
    endfunction : seq_rom
endpackage : fcg_pkg

// File: verilog/fcg_top.sv
// clock divider and table-driven data separator for the floppy section
`timescale 1ns/100ps

// Notes on behaviour
// R1: all three clocks come from dividing one 8 MHz oscillator tick
// R2: density select picks single or double density rates
// R3: controller 4 MHz; write 4/8 MHz; recovery 250/500 kHz
// R4: separator is a 32x8 table, address latch, two pulse flip-flops
// R5: gate low or no pulse: cycle through entries 10h to 1Fh
// R6: gate high and a read pulse: enter tracking mode
// R7: read pulse rising edge sets flop, page bit low, jump to 00h-0Fh
// R8: low entries retard or advance the window by one or two counts
// R9: correction depends on where the pulse lands within the window
// R10: page bit high again resumes free run in upper half
// R11: table contents follow the published microcode
// R12: each recovery tick latches low data nibble plus page bit
// R13: read data window is the msb of the latched count
module fcg_top (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_in,
    // from the disk controller
    input  wire logic read_mode_gate_in,
    input  wire logic double_density_select_in,
    // from the drive
    input  wire logic read_pulse_in,
    // clock enables out
    output logic      fdc_clk_en_out,
    output logic      write_clk_en_out,
    output logic      recovery_clock_en_out,
    // separator outputs
    output logic      read_data_window_out,
    output logic      table_page_bit_out
);

    // oscillator accumulator, divider and enables
    logic [fcg_pkg::ACC_W-1:0]  acc_reg,  acc_next;
    logic                       osc_reg,  osc_next;
    logic [fcg_pkg::DIV_W-1:0]  div_reg,  div_next;
    logic                       fdc_reg,  fdc_next;
    logic                       wr_reg,   wr_next;
    logic                       rec_reg,  rec_next;

    // separator state
    logic [fcg_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic                       cap_reg,  cap_next;
    logic                       rdp_reg,  rdp_next;
    logic                       win_reg,  win_next;
    logic [fcg_pkg::DATA_W-1:0] rom_data;
    // whole table held here; one indexed read instead of a decoder at each use
    logic [fcg_pkg::DATA_W-1:0] seq_table [2**fcg_pkg::ADDR_W];

    // true when the divider sits on a multiple of div
    function automatic logic div_hit(input logic [4:0] cnt, input int unsigned div);
        logic [4:0] mask;
        mask = 5'(div - 1);
        return (cnt & mask) == 5'h00;
    endfunction : div_hit

    // fractional accumulator makes an 8 MHz tick from 50 MHz; jitter is one mclk
    always_comb begin
        acc_next = acc_reg + fcg_pkg::ACC_W'(fcg_pkg::OSC_KHZ);   // [R1]
        osc_next = 1'b0;
        if (acc_next >= fcg_pkg::ACC_W'(fcg_pkg::MCLK_KHZ)) begin
            acc_next = acc_next - fcg_pkg::ACC_W'(fcg_pkg::MCLK_KHZ);
            osc_next = 1'b1;
        end
        div_next = osc_reg ? div_reg + 5'h01 : div_reg;
        fdc_next = osc_reg && div_hit(div_reg, fcg_pkg::CTRL_DIV);             // [R3]
        // density select picks the divide ratio for write and recovery
        if (double_density_select_in) begin                                   // [R2]
            wr_next  = osc_reg && div_hit(div_reg, fcg_pkg::WR_DD_DIV);        // [R3]
            rec_next = osc_reg && div_hit(div_reg, fcg_pkg::REC_DD_DIV);       // [R3]
        end else begin
            wr_next  = osc_reg && div_hit(div_reg, fcg_pkg::WR_SD_DIV);
            rec_next = osc_reg && div_hit(div_reg, fcg_pkg::REC_SD_DIV);
        end
    end

    // divider registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            acc_reg <= '0;
            osc_reg <= 1'b0;
            div_reg <= '0;
            fdc_reg <= 1'b0;
            wr_reg  <= 1'b0;
            rec_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            osc_reg <= osc_next;
            div_reg <= div_next;
            fdc_reg <= fdc_next;
            wr_reg  <= wr_next;
            rec_reg <= rec_next;
        end
    end

    // fill the table from the microcode; constant, so this settles once
    always_comb begin
        for (int i = 0; i < 2**fcg_pkg::ADDR_W; i++) begin
            seq_table[i] = fcg_pkg::seq_rom(fcg_pkg::ADDR_W'(i));   // [R4] [R11]
        end
    end

    // one table read per cycle at the latched address
    assign rom_data = seq_table[addr_reg];   // [R4]

    // separator: capture flop, edge flop, address latch
    always_comb begin
        rdp_next  = read_pulse_in;
        cap_next  = cap_reg;
        addr_next = addr_reg;
        win_next  = win_reg;
        // latch advances on the recovery tick; capture clears as the page bit is taken
        if (rec_reg) begin
            addr_next = {~cap_reg, rom_data[fcg_pkg::NIB_W-1:0]};        // [R5] [R12] [R8] [R9]
            win_next  = rom_data[fcg_pkg::WIN_BIT];                      // [R13]
            cap_next  = 1'b0;                                            // [R10]
        end
        // a rising pulse edge while gated sets capture, and wins over the clear
        if (read_mode_gate_in && read_pulse_in && !rdp_reg) begin
            cap_next = 1'b1;                                             // [R6] [R7]
        end
    end

    // separator registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdp_reg  <= 1'b0;
            cap_reg  <= 1'b0;
            addr_reg <= fcg_pkg::ADDR_RST;
            win_reg  <= 1'b0;
        end else begin
            rdp_reg  <= rdp_next;
            cap_reg  <= cap_next;
            addr_reg <= addr_next;
            win_reg  <= win_next;
        end
    end

    assign fdc_clk_en_out        = fdc_reg;
    assign write_clk_en_out      = wr_reg;
    assign recovery_clock_en_out = rec_reg;
    assign read_data_window_out  = win_reg;
    assign table_page_bit_out    = addr_reg[fcg_pkg::PAGE_BIT];

    // rate and sequencing checks next to the outputs they guard
    a_ctrl_spacing: assert property (@(posedge mclk_in) disable iff (rst_in) // [R3]
        fdc_reg |=> !fdc_reg [*8])
        else $error("controller enable too close");
    a_rec_dd_spacing: assert property (@(posedge mclk_in) disable iff (rst_in) // [R3]
        rec_reg && double_density_select_in |=> !rec_reg [*8])
        else $error("recovery enable too close");
    a_write_dd_rate: assert property (@(posedge mclk_in) disable iff (rst_in) // [R2]
        osc_reg && double_density_select_in |=> wr_reg)
        else $error("double density write enable missing");
    a_free_run_page: assert property (@(posedge mclk_in) disable iff (rst_in) // [R5]
        rec_reg && !cap_reg |=> addr_reg[fcg_pkg::PAGE_BIT])
        else $error("free run left upper page");
    a_jump_low_page: assert property (@(posedge mclk_in) disable iff (rst_in) // [R7]
        rec_reg && cap_reg |=> !addr_reg[fcg_pkg::PAGE_BIT])
        else $error("captured pulse did not jump low");
    a_pulse_capture: assert property (@(posedge mclk_in) disable iff (rst_in) // [R6]
        read_mode_gate_in && read_pulse_in && !rdp_reg |=> cap_reg)
        else $error("read pulse not captured");
    a_gate_blocks: assert property (@(posedge mclk_in) disable iff (rst_in) // [R5]
        !read_mode_gate_in && !cap_reg |=> !cap_reg)
        else $error("capture set with gate low");
    a_free_wrap: assert property (@(posedge mclk_in) disable iff (rst_in) // [R11]
        rec_reg && !cap_reg && addr_reg == {1'b1, fcg_pkg::NIB_TOP}
        |=> addr_reg == {1'b1, fcg_pkg::NIB_ZERO})
        else $error("free run did not wrap");
    a_window_msb: assert property (@(posedge mclk_in) disable iff (rst_in) // [R13]
        rec_reg |=> win_reg == addr_reg[fcg_pkg::WIN_BIT])
        else $error("window not count msb");
    a_retard_two: assert property (@(posedge mclk_in) disable iff (rst_in) // [R8]
        rec_reg && addr_reg == 5'h05 |=> addr_reg[3:0] == 4'h4)
        else $error("retard entry wrong");

    // divider checks: every enable rides on an oscillator tick
    a_osc_spacing: assert property (@(posedge mclk_in) disable iff (rst_in) // [R1]
        osc_reg |=> !osc_reg [*5])
        else $error("oscillator tick too close");
    a_enable_on_tick: assert property (@(posedge mclk_in) disable iff (rst_in) // [R1]
        fdc_reg || wr_reg || rec_reg |-> $past(osc_reg))
        else $error("enable without oscillator tick");
    a_rec_with_ctrl: assert property (@(posedge mclk_in) disable iff (rst_in) // [R1]
        rec_reg |-> fdc_reg)
        else $error("recovery enable off the controller phase");
    a_write_spacing: assert property (@(posedge mclk_in) disable iff (rst_in) // [R3]
        wr_reg |=> !wr_reg [*5])
        else $error("write enable too close");
    a_rec_sd_spacing: assert property (@(posedge mclk_in) disable iff (rst_in) // [R3]
        rec_reg && !double_density_select_in |=> !rec_reg [*8])
        else $error("single density recovery enable too close");
    a_write_sd_rate: assert property (@(posedge mclk_in) disable iff (rst_in) // [R2]
        wr_reg && !$past(double_density_select_in) |-> fdc_reg)
        else $error("single density write enable off rate");

    // separator checks: latch holds between ticks, capture lifetime
    a_window_holds: assert property (@(posedge mclk_in) disable iff (rst_in) // [R13]
        !rec_reg |=> $stable(win_reg))
        else $error("window moved between recovery ticks");
    a_addr_holds: assert property (@(posedge mclk_in) disable iff (rst_in) // [R12]
        !rec_reg |=> $stable(addr_reg))
        else $error("address latch moved between recovery ticks");
    a_cap_clears: assert property (@(posedge mclk_in) disable iff (rst_in) // [R10]
        rec_reg && !(read_mode_gate_in && read_pulse_in && !rdp_reg) |=> !cap_reg)
        else $error("capture not cleared at recovery tick");
    a_capture_holds: assert property (@(posedge mclk_in) disable iff (rst_in) // [R7]
        cap_reg && !rec_reg |=> cap_reg)
        else $error("capture lost before recovery tick");
    a_advance_one: assert property (@(posedge mclk_in) disable iff (rst_in) // [R8]
        rec_reg && addr_reg == 5'h0C |=> addr_reg[3:0] == 4'hE)
        else $error("advance by one entry wrong");
    a_advance_two: assert property (@(posedge mclk_in) disable iff (rst_in) // [R9]
        rec_reg && addr_reg == 5'h09 |=> addr_reg[3:0] == 4'hC)
        else $error("advance by two entry wrong");
    a_free_run_count: assert property (@(posedge mclk_in) disable iff (rst_in) // [R5]
        rec_reg && !cap_reg && addr_reg[fcg_pkg::PAGE_BIT]
        |=> addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
        else $error("free run count did not step by one");

endmodule : fcg_top

// File: verification/fcg_drive_model.sv
// drive read channel model: read pulses at a spacing with random jitter
`timescale 1ns/100ps
module fcg_drive_model (
    // clock and control
    input  wire logic       clk_in,
    input  wire logic       en_in,
    input  wire logic [7:0] gap_in,
    // raw read pulse toward the separator
    output logic            pulse_out
);
    // pulse unknown until the first falling edge, which falls inside reset
    int cnt = 0;
    // one-cycle pulses, jitter moves them across the window centre
    always @(negedge clk_in) begin
        pulse_out <= en_in && (cnt == 0);
        cnt <= (!en_in || cnt == 0) ? int'(gap_in) + $urandom_range(0, 7) : cnt - 1;
    end
endmodule : fcg_drive_model

// File: verification/fcg_top_tb_top.sv
// self-checking bench for the clock divider and data separator
`timescale 1ns/100ps
module fcg_top_tb_top;
    logic mclk_in = 1'b0, rst_in = 1'b1, gate = 1'b0, dd = 1'b0, rp, pen = 1'b0;
    logic fdc_en, wr_en, rec_en, win, page;
    logic [7:0] gap = 8'h40;
    logic [4:0] m_addr;
    logic m_cap, m_prev, m_win;
    logic [3:0] m_nib;
    int err_count = 0, comparisons = 0;
    // entries 00h..0Fh low nibbles, entry 0 in the lowest nibble
    localparam logic [63:0] LOW_NIB = 64'h10FEEDCB65433211;
    always #10 mclk_in = ~mclk_in;
    fcg_drive_model i_fcg_drive_model (.clk_in(mclk_in), .en_in(pen), .gap_in(gap),
        .pulse_out(rp));
    fcg_top i_fcg_top (.mclk_in(mclk_in), .rst_in(rst_in), .read_mode_gate_in(gate),
        .double_density_select_in(dd), .read_pulse_in(rp), .fdc_clk_en_out(fdc_en),
        .write_clk_en_out(wr_en), .recovery_clock_en_out(rec_en),
        .read_data_window_out(win), .table_page_bit_out(page));
    function automatic logic [3:0] next_nib(input logic [4:0] a);
        return a[4] ? a[3:0] + 4'h1 : LOW_NIB[a[3:0]*4 +: 4];
    endfunction : next_nib
    // reference sequencer, paced by the design's recovery tick
    always @(posedge mclk_in) begin
        if (rst_in) begin
            m_addr = 5'h10;
            m_cap = 1'b0;
            m_win = 1'b0;
        end else begin
            if (rec_en) begin
                m_nib = next_nib(m_addr);
                m_win = m_nib[3];
                m_addr = {~m_cap, m_nib};
            end
            m_cap = (rp && !m_prev && gate) || (m_cap && !rec_en);
        end
        m_prev = rp;
    end
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            err_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // pulse counts over 10000 cycles (200 us) against the density rates
    task automatic rates(input logic d);
        int f, w, r;
        f = 0;
        w = 0;
        r = 0;
        dd = d;
        repeat (400) @(negedge mclk_in);
        repeat (10000) begin
            @(negedge mclk_in);
            f += int'(fdc_en === 1'b1);
            w += int'(wr_en === 1'b1);
            r += int'(rec_en === 1'b1);
        end
        chk(f >= 799 && f <= 801, "controller clock rate");
        chk(w >= (d ? 1599 : 799) && w <= (d ? 1601 : 801), "write clock rate");
        chk(r >= (d ? 99 : 49) && r <= (d ? 101 : 51), "recovery clock rate");
    endtask : rates
    // compare page bit and window with the reference every cycle
    task automatic run(input int n);
        repeat (n) begin
            @(negedge mclk_in);
            chk(page === m_addr[4], "page bit");
            chk(win === m_win, "read data window");
        end
    endtask : run
    initial begin
        void'($urandom(32'h6f58));
        repeat (3) @(negedge mclk_in);
        chk(fdc_en === 1'b0 && wr_en === 1'b0 && rec_en === 1'b0 && win === 1'b0 && page === 1'b1,
            "reset");
        rst_in = 1'b0;
        rates(1'b0);
        rates(1'b1);
        pen = 1'b1;
        run(3000); // pulses with the gate low are ignored
        gate = 1'b1;
        pen = 1'b0;
        run(3000); // gate high without pulses keeps free running
        repeat (40) begin
            gate = $urandom_range(0, 3) != 0;
            dd = $urandom_range(0, 1);
            pen = $urandom_range(0, 4) != 0;
            gap = 8'($urandom_range(20, 250));
            run(500);
        end
        // second reset in mid-run, then free run must restart at entry 10h
        rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk(fdc_en === 1'b0 && wr_en === 1'b0 && rec_en === 1'b0 && win === 1'b0 && page === 1'b1,
            "mid-run reset");
        rst_in = 1'b0;
        run(600);
        print_verdict();
    end
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule : fcg_top_tb_top
